/* hdl/acs_sequencer.sv */
// Conversion sequencer for a 10-bit multiplexed analog-to-digital converter
`timescale 1ns/10ps
module acs_sequencer #(
  parameter int CAL_CYCLES = acs_pkg::ACS_CAL_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Software control
  input wire acs_pkg::acs_ctrl_t ctrl,
  input wire logic start,
  input wire logic stop,
  input wire logic inject_req,
  input wire logic [acs_pkg::ACS_CH_W-1:0] inject_channel,
  input wire logic result_read,
  input wire logic inject_read,
  // Analog core interface
  output logic [acs_pkg::ACS_CH_W-1:0] mux_channel,
  output logic mux_group,
  output logic sample,
  output logic convert_strobe,
  input wire logic convert_done,
  input wire logic [acs_pkg::ACS_RES_W-1:0] convert_value,
  output logic cal_run,
  // Digital view of the channel pins
  input wire logic [acs_pkg::ACS_GRP_A-1:0] pins_group_a,
  input wire logic [acs_pkg::ACS_GRP_B-1:0] pins_group_b,
  output logic [acs_pkg::ACS_GRP_A-1:0] digital_group_a,
  output logic [acs_pkg::ACS_GRP_B-1:0] digital_group_b,
  // Status and results
  output logic converter_busy_flag,
  output logic running,
  output acs_pkg::acs_result_t conversion_result_register,
  output acs_pkg::acs_result_t injection_result_register,
  output logic result_valid,
  output logic inject_valid,
  output logic complete_irq,
  output logic inject_irq,
  output logic overrun_irq
);
  import acs_pkg::*;

  localparam int CAL_W = $clog2(CAL_CYCLES + 1);

  typedef enum logic [2:0] {
    ST_CAL, ST_IDLE, ST_SAMPLE, ST_CONVERT, ST_WAIT, ST_HOLD
  } acs_state_t;

  acs_state_t state;
  logic [CAL_W-1:0] cal_count;
  logic [ACS_PER_W-1:0] period_count;
  logic [ACS_CH_W-1:0] cur_channel;
  logic injecting;
  logic inject_pending;
  logic [ACS_CH_W-1:0] inject_ch;
  logic stop_pending;
  acs_result_t held;

  // Continuous modes loop until a stop request; scan modes walk channels downward
  function automatic logic is_cont(input acs_mode_t m);
    return (m == ACS_CONT_ONE) || (m == ACS_SCAN_CONT);
  endfunction

  function automatic logic is_scan(input acs_mode_t m);
    return (m == ACS_SCAN_ONCE) || (m == ACS_SCAN_CONT);
  endfunction

  // Zero period would stall nothing, so treat it as one cycle
  function automatic logic [ACS_PER_W-1:0] eff_period(input logic [ACS_PER_W-1:0] p);
    return (p == '0) ? ACS_PER_ONE : p;
  endfunction

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cal_count <= '0;
    end else if (state == ST_CAL) begin
      cal_count <= cal_count + CAL_W'(1);
    end
  end

  assign converter_busy_flag = (state == ST_CAL);
  assign cal_run = (state == ST_CAL);
  assign running = (state != ST_CAL) && (state != ST_IDLE);

  // Injection request latch, honoured only in continuous modes
  // Only one injection queues; a second request while one is pending is dropped
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      inject_pending <= 1'b0;
      inject_ch <= ACS_CH_ZERO;
    end else if (inject_req && !inject_pending && running && is_cont(ctrl.mode)) begin
      inject_pending <= 1'b1;
      inject_ch <= inject_channel;
    end else if (state == ST_SAMPLE && period_count == '0 && inject_pending && !injecting) begin
      inject_pending <= 1'b0;
    end
  end

  // Stop request stays pending until the sequencer next returns to idle
  // Never cuts a conversion short, so no half-finished result is stored
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      stop_pending <= 1'b0;
    end else if (state == ST_IDLE) begin
      stop_pending <= 1'b0;
    end else if (stop) begin
      stop_pending <= 1'b1;
    end
  end

  // Main sequencing state machine
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_CAL;
      period_count <= '0;
      cur_channel <= ACS_CH_ZERO;
      injecting <= 1'b0;
    end else begin
      case (state)
        ST_CAL: begin
          // no start honoured until calibration ends
          if (cal_count == CAL_W'(CAL_CYCLES - 1)) begin
            state <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          // start ignored while busy (never reached in calibration)
          if (start) begin
            cur_channel <= ctrl.channel;
            period_count <= eff_period(ctrl.sample_period);
            state <= ST_SAMPLE;
          end
        end
        ST_SAMPLE: begin
          if (period_count == '0) begin
            if (inject_pending && !injecting) begin
              injecting <= 1'b1;
              period_count <= eff_period(ctrl.sample_period);
            end else begin
              period_count <= eff_period(ctrl.conv_period);
              state <= ST_CONVERT;
            end
          end else begin
            period_count <= period_count - ACS_PER_ONE;
          end
        end
        ST_CONVERT: begin
          if (period_count == '0) begin
            state <= ST_WAIT;
          end else begin
            period_count <= period_count - ACS_PER_ONE;
          end
        end
        ST_WAIT: begin
          if (convert_done) begin
            if (injecting) begin
              // resume the interrupted mode on the same channel
              injecting <= 1'b0;
              period_count <= eff_period(ctrl.sample_period);
              state <= ST_SAMPLE;
            end else if (is_cont(ctrl.mode) && ctrl.wait_for_read_enable && result_valid && !result_read) begin
              state <= ST_HOLD;
            end else begin
              state <= ST_IDLE;
              // single conversion stops after one result
              if (ctrl.mode != ACS_SINGLE_ONE && !stop_pending) begin
                if (is_scan(ctrl.mode) && cur_channel != ACS_CH_ZERO) begin
                  cur_channel <= cur_channel - 5'h01;
                  state <= ST_SAMPLE;
                end else if (is_cont(ctrl.mode)) begin
                  cur_channel <= is_scan(ctrl.mode) ? ctrl.channel : cur_channel;
                  state <= ST_SAMPLE;
                end
              end
              period_count <= eff_period(ctrl.sample_period);
            end
          end
        end
        ST_HOLD: begin
          if (result_read) begin
            period_count <= eff_period(ctrl.sample_period);
            if (stop_pending) begin
              state <= ST_IDLE;
            end else if (is_scan(ctrl.mode) && cur_channel != ACS_CH_ZERO) begin
              cur_channel <= cur_channel - 5'h01;
              state <= ST_SAMPLE;
            end else begin
              cur_channel <= is_scan(ctrl.mode) ? ctrl.channel : cur_channel;
              state <= ST_SAMPLE;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Group select is live: changing it during sampling affects that sample
  // multiplexer selection
  assign mux_channel = injecting ? inject_ch : cur_channel;
  assign mux_group = ctrl.group_sel;
  assign sample = (state == ST_SAMPLE);
  assign convert_strobe = (state == ST_CONVERT) && (period_count == '0);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      digital_group_a <= '0;
      digital_group_b <= '0;
    end else begin
      digital_group_a <= pins_group_a;
      digital_group_b <= pins_group_b;
    end
  end

  // Temporary buffer for a result waiting on a read
  // Captured on every regular result so a hold can release it unchanged
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      held <= '0;
    end else if (state == ST_WAIT && convert_done && !injecting) begin
      held <= '{channel: cur_channel, value: convert_value};
    end
  end

  // Result register, valid flag and events; a new result wins over a read
  // A read landing with a new result must not hide that new result
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      conversion_result_register <= '0;
      result_valid <= 1'b0;
      complete_irq <= 1'b0;
      overrun_irq <= 1'b0;
    end else begin
      complete_irq <= 1'b0;
      overrun_irq <= 1'b0;
      if (state == ST_WAIT && convert_done && !injecting && !(state == ST_WAIT &&
          is_cont(ctrl.mode) && ctrl.wait_for_read_enable && result_valid && !result_read)) begin
        conversion_result_register <= '{channel: cur_channel, value: convert_value};
        result_valid <= 1'b1;
        complete_irq <= 1'b1;
        overrun_irq <= result_valid && !result_read;
      end else if (state == ST_HOLD && result_read) begin
        conversion_result_register <= held;
        result_valid <= 1'b1;
        complete_irq <= 1'b1;
      end else if (result_read) begin
        result_valid <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      injection_result_register <= '0;
      inject_valid <= 1'b0;
      inject_irq <= 1'b0;
    end else begin
      inject_irq <= 1'b0;
      if (state == ST_WAIT && convert_done && injecting) begin
        injection_result_register <= '{channel: inject_ch, value: convert_value};
        inject_valid <= 1'b1;
        inject_irq <= 1'b1;
      end else if (inject_read) begin
        inject_valid <= 1'b0;
      end
    end
  end
endmodule // acs_sequencer

/* hdl/acs_pkg.sv */
// Package for the converter sequencer: constants, modes and port carriers
package acs_pkg;
  localparam int ACS_RES_W = 10;
  localparam int ACS_GRP_A = 16;
  localparam int ACS_GRP_B = 8;
  localparam int ACS_CH_W = 5;
  localparam int ACS_CAL_CYCLES = 40630;
  localparam int ACS_PER_W = 8;
  localparam logic [ACS_CH_W-1:0] ACS_CH_ZERO = 5'h00;
  localparam logic [ACS_PER_W-1:0] ACS_PER_ONE = 8'h01;

  // Conversion modes
  typedef enum logic [1:0] {
    ACS_SINGLE_ONE = 2'h0,
    ACS_CONT_ONE = 2'h1,
    ACS_SCAN_ONCE = 2'h2,
    ACS_SCAN_CONT = 2'h3
  } acs_mode_t;

  // Converter control bits, steered by software
  typedef struct packed {
    acs_mode_t mode;
    logic wait_for_read_enable;
    logic group_sel;
    logic [ACS_CH_W-1:0] channel;
    logic [ACS_PER_W-1:0] sample_period;
    logic [ACS_PER_W-1:0] conv_period;
  } acs_ctrl_t;

  // A completed result with its channel
  typedef struct packed {
    logic [ACS_CH_W-1:0] channel;
    logic [ACS_RES_W-1:0] value;
  } acs_result_t;
endpackage

/* verification/acs_sequencer_props.sv */
// Port assertions for the conversion sequencer
`timescale 1ns/10ps
module acs_sequencer_props #(
  parameter int CAL_CYCLES = 20
) (
  // Clock, reset and control
  input wire logic mclk,
  input wire logic rstn,
  input wire acs_pkg::acs_ctrl_t ctrl,
  input wire logic result_read,
  input wire logic [acs_pkg::ACS_GRP_A-1:0] pins_group_a,
  input wire logic [acs_pkg::ACS_GRP_B-1:0] pins_group_b,
  // Observed outputs
  input wire logic [acs_pkg::ACS_GRP_A-1:0] digital_group_a,
  input wire logic [acs_pkg::ACS_GRP_B-1:0] digital_group_b,
  input wire logic mux_group,
  input wire logic sample,
  input wire logic convert_strobe,
  input wire logic converter_busy_flag,
  input wire logic running,
  input wire logic result_valid,
  input wire logic inject_valid,
  input wire logic complete_irq,
  input wire logic inject_irq,
  input wire logic overrun_irq
);
  import acs_pkg::*;
  logic [15:0] busy_cnt;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  // Busy cycles since release, bounds calibration
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      busy_cnt <= 16'h0;
    end else if (converter_busy_flag) begin
      busy_cnt <= busy_cnt + 16'h1;
    end
  end
  cal_length_a: assert property (busy_cnt <= 16'(CAL_CYCLES))
    else $error("calibration too long");
  busy_hold_a: assert property (!converter_busy_flag |=> !converter_busy_flag)
    else $error("busy rose again");
  busy_idle_a: assert property (converter_busy_flag |-> !running && !sample && !convert_strobe)
    else $error("activity while busy");
  irq_pulse_a: assert property (complete_irq |-> result_valid ##1 !complete_irq)
    else $error("complete pulse wrong");
  overrun_cause_a: assert property (overrun_irq |-> complete_irq && $past(result_valid))
    else $error("overrun without unread result");
  wfr_hold_a: assert property (ctrl.wait_for_read_enable && ctrl.mode[0] && result_valid && !result_read
    |=> !overrun_irq)
    else $error("overrun while waiting for read");
  strobe_pulse_a: assert property (convert_strobe |=> !convert_strobe)
    else $error("strobe longer than one cycle");
  group_sel_a: assert property (sample |-> mux_group == ctrl.group_sel)
    else $error("wrong channel group");
  pins_copy_a: assert property ($past(rstn) |-> digital_group_a == $past(pins_group_a))
    else $error("digital copy stale");
  pins_copy_b_a: assert property ($past(rstn) |-> digital_group_b == $past(pins_group_b))
    else $error("digital copy of second group stale");
  inject_flag_a: assert property (inject_irq |-> inject_valid ##1 !inject_irq)
    else $error("inject result flag wrong");
endmodule // acs_sequencer_props
bind acs_sequencer acs_sequencer_props #(.CAL_CYCLES(CAL_CYCLES)) u_props (.mclk, .rstn, .ctrl, .result_read,
  .pins_group_a, .pins_group_b, .digital_group_a, .digital_group_b, .mux_group, .sample, .convert_strobe,
  .converter_busy_flag, .running,
  .result_valid, .inject_valid, .complete_irq, .inject_irq, .overrun_irq);

/* verification/tb_top.sv */
// Self-checking bench for the conversion sequencer
`timescale 1ns/10ps
module tb_top;
  import acs_pkg::*;
  logic mclk = 0, rstn = 0, start = 0, stop = 0, inject_req = 0, result_read = 0, inject_read = 0;
  logic convert_done = 0, auto_read = 1, rd_req = 0, unread = 0;
  logic [9:0] convert_value = 10'h0;
  logic [4:0] inject_channel = 5'h0, mux_channel;
  logic [15:0] pins_a = 16'h0, dig_a;
  logic [7:0] pins_b = 8'h0, dig_b;
  logic mux_group, sample, convert_strobe, cal_run, busy, running, rv, iv, complete_irq, inject_irq, overrun_irq;
  acs_ctrl_t ctrl = '0;
  acs_result_t res, inj;
  logic [4:0] exp_ch[$], inj_ch[$], seen_ch[$], e_ch;
  logic [9:0] exp_val[$];
  int n_mismatch = 0, compares = 0, n_done = 0;
  acs_sequencer #(.CAL_CYCLES(20)) dut (.mclk, .rstn, .ctrl, .start, .stop, .inject_req, .inject_channel,
    .result_read, .inject_read, .mux_channel, .mux_group, .sample, .convert_strobe, .convert_done,
    .convert_value, .cal_run, .pins_group_a(pins_a), .pins_group_b(pins_b), .digital_group_a(dig_a),
    .digital_group_b(dig_b), .converter_busy_flag(busy), .running, .conversion_result_register(res),
    .injection_result_register(inj), .result_valid(rv), .inject_valid(iv), .complete_irq, .inject_irq,
    .overrun_irq);
  initial begin
    forever #4 mclk = ~mclk;
  end
  task automatic tick();
    @(posedge mclk);
    #1;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Pins and software reads, refreshed every cycle so no pulse is missed
  initial forever begin
    tick();
    pins_a = 16'($urandom);
    pins_b = 8'($urandom);
    result_read = rd_req | (auto_read & complete_irq);
    inject_read = inject_irq;
  end
  // Analog core stand-in; notes the channel presented at the strobe
  initial forever begin
    tick();
    if (convert_strobe === 1'b1) begin
      seen_ch.push_back(mux_channel);
      repeat (2) tick();
      convert_value = 10'($urandom);
      convert_done = 1;
      exp_val.push_back(convert_value);
      tick();
      convert_done = 0;
      convert_value = ~convert_value;
    end
  end
  // Result watcher pops the oldest note
  always begin
    tick();
    #1;
    if (complete_irq === 1'b1) begin
      e_ch = exp_ch.pop_front();
      check({1'b0, res}, {1'b0, e_ch, exp_val.pop_front()});
      check(16'(seen_ch.pop_front()), 16'(e_ch));
      check(16'(overrun_irq), 16'(unread));
      unread = 1;
      n_done++;
    end
    if (inject_irq === 1'b1) begin
      e_ch = inj_ch.pop_front();
      check({1'b0, inj}, {1'b0, e_ch, exp_val.pop_front()});
      check(16'(seen_ch.pop_front()), 16'(e_ch));
    end
    if (result_read === 1'b1) unread = 0;
  end
  task automatic do_reset();
    int t;
    rstn = 0;
    unread = 0;
    repeat (2) tick();
    rstn = 1;
    start = 1;
    check(16'(cal_run), 16'h1);
    t = 0;
    while (busy === 1'b1 && t < 50000) begin
      tick();
      t++;
    end
    start = 0;
    check(16'(t <= 20 && t > 0), 16'h1);
    check(16'(cal_run), 16'h0);
    repeat (3) tick();
    check(16'(running), 16'h0);
    $display("reset test done");
  endtask
  task automatic run(input acs_mode_t m, input logic [4:0] ch, input int n, input logic wfr, input logic ij);
    int d, t;
    ctrl = {m, wfr, 1'($urandom), ch, 8'($urandom % 4), 8'($urandom % 4)};
    for (int i = 0; i < n; i++) exp_ch.push_back(m[1] ? 5'(ch - i % (ch + 1)) : ch);
    // Clear a leftover unread result so the first conversion is not held
    if (wfr) begin
      @(negedge mclk) rd_req = 1;
      @(negedge mclk) rd_req = 0;
      tick();
    end
    start = 1;
    tick();
    start = 0;
    for (int i = 0; i < n; i++) begin
      d = n_done;
      if (ij && i == 1) begin
        inject_channel = 5'h07;
        inj_ch.push_back(5'h07);
        inject_req = 1;
        tick();
        inject_req = 0;
      end
      if (wfr && i == 1) begin
        repeat (40) tick();
        check(16'(n_done), 16'(d));
        @(negedge mclk) rd_req = 1;
        auto_read = 1;
        @(negedge mclk) rd_req = 0;
        tick();
      end
      if (m[0] && i == n - 1) begin
        stop = 1;
        tick();
        stop = 0;
      end
      t = 0;
      while (n_done == d && t < 2000) begin
        tick();
        t++;
      end
      check(16'(n_done), 16'(d + 1));
    end
    t = 0;
    while (running !== 1'b0 && t < 200) begin
      tick();
      t++;
    end
    repeat (20) tick();
    check(16'(running), 16'h0);
    $display("mode %0d test done", m);
  endtask
  initial begin
    void'($urandom(4));
    do_reset();
    for (int m = 0; m < 4; m++) run(acs_mode_t'(m), 5'h3, (m == 0) ? 1 : 4, 1'b0, 1'b0);
    run(ACS_CONT_ONE, 5'h2, 5, 1'b0, 1'b1);
    run(ACS_SCAN_CONT, 5'h3, 6, 1'b0, 1'b1);
    auto_read = 0;
    run(ACS_CONT_ONE, 5'h1, 3, 1'b0, 1'b0);
    run(ACS_SCAN_ONCE, 5'h2, 3, 1'b0, 1'b0);
    run(ACS_SCAN_CONT, 5'h4, 3, 1'b1, 1'b0);
    do_reset();
    run(ACS_SINGLE_ONE, 5'h1f, 1, 1'b0, 1'b0);
    finish_test();
  end
  // Watchdog against a hang
  initial begin
    repeat (30000) @(posedge mclk);
    n_mismatch++;
    finish_test();
  end
endmodule // tb_top
